/* rtl/register_page_context_stack.sv */
`timescale 1ns/100ps
`default_nettype none

module register_page_context_stack (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_en,
   // Core register port
   input wire page_stack_pkg::reg_access_s reg_access,
   output logic [7:0] reg_rdata,
   // Core interrupt strobes
   input wire page_stack_pkg::irq_event_s irq_event,
   // Current page to the register decoder
   output logic [7:0] page_select_out,
   output logic auto_page_enable_out
);

   // Kinds of work the stack can do in one cycle
   typedef enum logic [1:0] {
      op_idle,
      op_push,
      op_pop,
      op_soft_write
   } stack_op_e;

   // Top of the stack: the page the core uses now
   logic [7:0] page_select;
   // Second level: page to restore on the next return
   logic [7:0] page_stack_middle;
   // Bottom level: deepest saved page, lost on a third push
   logic [7:0] page_stack_bottom;
   // Control bit that lets interrupts push and pop
   logic auto_page_enable;

   // Next values of the stack levels
   logic [7:0] next_page_select;
   logic [7:0] next_page_stack_middle;
   logic [7:0] next_page_stack_bottom;

   // Next value of the control bit
   logic next_auto_page_enable;

   // Next values of the registered outputs
   logic [7:0] next_reg_rdata;
   logic [7:0] next_page_select_out;
   logic next_auto_page_enable_out;

   // Work chosen for this cycle
   stack_op_e op;

   // Pick one kind of work per cycle
   // Entry beats return, and both beat a software write, so a
   // write that collides with a taken strobe is dropped. The core
   // never gives entry and return together, but if it did the
   // push wins and the return is lost with the write.
   function automatic stack_op_e decode_op(input logic entry,
                                           input logic ret,
                                           input logic write,
                                           input logic enable);
      decode_op = op_idle;
      if (enable && entry) begin
         decode_op = op_push;
      end else if (enable && ret) begin
         decode_op = op_pop;
      end else if (write) begin
         decode_op = op_soft_write;
      end
   endfunction : decode_op

   // Read value of a selected register
   // Reserved control bits are built from zero each time, so no
   // write can ever make them read back as one.
   function automatic logic [7:0] read_reg(input logic [1:0] sel,
                                           input logic [7:0] pg,
                                           input logic [7:0] mid,
                                           input logic [7:0] bot,
                                           input logic en);
      logic [7:0] ctl;
      ctl = '0;
      ctl[page_stack_pkg::enable_bit] = en;
      if (sel == page_stack_pkg::sel_page) begin
         read_reg = pg;
      end else if (sel == page_stack_pkg::sel_middle) begin
         read_reg = mid;
      end else if (sel == page_stack_pkg::sel_bottom) begin
         read_reg = bot;
      end else begin
         read_reg = ctl;
      end
   endfunction : read_reg

   // Decode of the strobes and the software write
   // Strobes are only honoured while automatic paging is on;
   // with it off the stack behaves as three plain registers.
   always_comb begin
      op = decode_op(irq_event.entry, irq_event.ret, reg_access.write,
                     auto_page_enable);
   end

   // Next stack levels for push, pop and software writes
   // A push moves every level down by one and drops the old
   // bottom; a pop moves every level up and fills the bottom
   // with the empty value, since nothing lies below it.
   always_comb begin
      next_page_select = page_select;
      next_page_stack_middle = page_stack_middle;
      next_page_stack_bottom = page_stack_bottom;
      case (op)
         op_push: begin
            next_page_select = irq_event.entry_page;
            next_page_stack_middle = page_select;
            next_page_stack_bottom = page_stack_middle;
         end
         op_pop: begin
            next_page_select = page_stack_middle;
            next_page_stack_middle = page_stack_bottom;
            next_page_stack_bottom = page_stack_pkg::bottom_empty;
         end
         op_soft_write: begin
            // Only the addressed level changes; nothing shifts
            if (reg_access.sel == page_stack_pkg::sel_page) begin
               next_page_select = reg_access.wdata;
            end else if (reg_access.sel == page_stack_pkg::sel_middle) begin
               next_page_stack_middle = reg_access.wdata;
            end else if (reg_access.sel == page_stack_pkg::sel_bottom) begin
               next_page_stack_bottom = reg_access.wdata;
            end
         end
         default: begin
            // Idle cycle: all levels hold
            next_page_select = page_select;
         end
      endcase
   end

   // Stack level registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         page_select <= page_stack_pkg::page_reset;
         page_stack_middle <= page_stack_pkg::page_reset;
         page_stack_bottom <= page_stack_pkg::bottom_empty;
      end else if (clock_en) begin
         page_select <= next_page_select;
         page_stack_middle <= next_page_stack_middle;
         page_stack_bottom <= next_page_stack_bottom;
      end
   end

   // Next control bit
   // Only bit 0 is stored; the other bits are never kept, so
   // writes to them vanish without a trace.
   always_comb begin
      next_auto_page_enable = auto_page_enable;
      if (op == op_soft_write && reg_access.sel == page_stack_pkg::sel_control) begin
         next_auto_page_enable = reg_access.wdata[page_stack_pkg::enable_bit];
      end
   end

   // Control bit register, enabled out of reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         auto_page_enable <= page_stack_pkg::control_reset[page_stack_pkg::enable_bit];
      end else if (clock_en) begin
         auto_page_enable <= next_auto_page_enable;
      end
   end

   // Next read data and output copies
   // Read data shows the register as it stands after this
   // cycle's update, so a read never returns a stale level.
   always_comb begin
      next_reg_rdata = read_reg(reg_access.sel, next_page_select, next_page_stack_middle,
                                next_page_stack_bottom, next_auto_page_enable);
      next_page_select_out = next_page_select;
      next_auto_page_enable_out = next_auto_page_enable;
   end

   // Output registers
   // Kept as separate flops so every output leaves a register
   // and the page decoder sees no combinational path.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
         page_select_out <= page_stack_pkg::page_reset;
         auto_page_enable_out <= page_stack_pkg::control_reset[page_stack_pkg::enable_bit];
      end else if (clock_en) begin
         reg_rdata <= next_reg_rdata;
         page_select_out <= next_page_select_out;
         auto_page_enable_out <= next_auto_page_enable_out;
      end
   end

   // Limits a user must know:
   // - a third nested entry loses the oldest saved page for good;
   // - turning automatic paging off in a service routine also stops
   //   the pop on return, so the routine must restore its own page;
   // - a software write in the same cycle as a taken strobe is lost;
   // - while the clock enable is low, strobes and writes are ignored,
   //   not queued, so the core must hold them off in that time.

endmodule : register_page_context_stack

`default_nettype wire

/* include/page_stack_pkg.sv */
package page_stack_pkg;

   // Register layout of the page stack
   localparam int page_width = 8;
   localparam logic [7:0] page_reset = 8'h00;
   localparam logic [7:0] bottom_empty = 8'h00;
   localparam logic [7:0] control_reset = 8'h01;
   localparam int enable_bit = 0;

   // Register selectors on the core's register port
   typedef enum logic [1:0] {
      sel_page,
      sel_middle,
      sel_bottom,
      sel_control
   } reg_sel_e;

   // Software register access from the core
   typedef struct packed {
      logic write;
      logic [1:0] sel;
      logic [7:0] wdata;
   } reg_access_s;

   // Interrupt entry and return strobes from the core
   typedef struct packed {
      logic entry;
      logic [7:0] entry_page;
      logic ret;
   } irq_event_s;

endpackage : page_stack_pkg

/* sim/page_stack_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module page_stack_sva (
   // Watched ports
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_en,
   input wire page_stack_pkg::reg_access_s reg_access,
   input wire logic [7:0] reg_rdata,
   input wire page_stack_pkg::irq_event_s irq_event,
   input wire logic [7:0] page_select_out,
   input wire logic auto_page_enable_out
);
   logic en, ent, pop, sw;
   logic [1:0] s;
   // Taken events and selector shorthand
   assign en = auto_page_enable_out & clock_en;
   assign ent = irq_event.entry & en;
   assign pop = irq_event.ret & en;
   assign sw = reg_access.write & clock_en & !ent & !pop;
   assign s = reg_access.sel;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_entry_load: assert property (ent |=> page_select_out == $past(irq_event.entry_page))
      else $error("entry page not loaded");
   a_page_hold: assert property (!ent && !pop && !(sw && s == 2'h0) |=> $stable(page_select_out))
      else $error("page moved");
   a_page_write: assert property (sw && s == 2'h0 |=> page_select_out == $past(reg_access.wdata))
      else $error("page write lost");
   a_ctrl_write: assert property (sw && s == 2'h3 |=> auto_page_enable_out == $past(reg_access.wdata[0]))
      else $error("enable write lost");
   a_ctrl_hold: assert property (!(sw && s == 2'h3) |=> $stable(auto_page_enable_out))
      else $error("enable moved");
   a_ctrl_reserved: assert property (clock_en && s == 2'h3 |=> reg_rdata[7:1] == 7'h00)
      else $error("reserved bits set");
   a_ctrl_read: assert property (clock_en && s == 2'h3 |=> reg_rdata[0] == auto_page_enable_out)
      else $error("enable readback");
   a_page_read: assert property (clock_en && s == 2'h0 |=> reg_rdata == page_select_out)
      else $error("page readback");
   c_entry: cover property (ent);
   c_pop: cover property (pop);
   c_ctrl: cover property (sw && s == 2'h3);
endmodule : page_stack_sva
bind register_page_context_stack page_stack_sva u_sva (.clock(clock), .rst(rst),
   .clock_en(clock_en), .reg_access(reg_access), .reg_rdata(reg_rdata), .irq_event(irq_event),
   .page_select_out(page_select_out), .auto_page_enable_out(auto_page_enable_out));
`default_nettype wire

/* sim/core_irq_model.sv */
`timescale 1ns/100ps
`default_nettype none
module core_irq_model (
   // Clock and strobes
   input wire logic clock,
   output var page_stack_pkg::irq_event_s irq_event
);
   initial irq_event = '0;
   // One-cycle entry pulse, page scrambled once released
   task enter(input logic [7:0] p);
      @(posedge clock) irq_event <= '{1'b1, p, 1'b0};
      @(posedge clock) irq_event <= '{1'b0, ~p, 1'b0};
   endtask : enter
   // One-cycle return pulse
   task leave();
      @(posedge clock) irq_event <= '{1'b0, 8'h5a, 1'b1};
      @(posedge clock) irq_event <= '{1'b0, 8'ha5, 1'b0};
   endtask : leave
endmodule : core_irq_model
`default_nettype wire

/* sim/register_page_context_stack_test.sv */
`timescale 1ns/100ps
`default_nettype none
module register_page_context_stack_test;
   logic clock, rst, clock_en, auto_page_enable_out;
   logic [7:0] reg_rdata, page_select_out;
   page_stack_pkg::reg_access_s reg_access;
   page_stack_pkg::irq_event_s irq_event;
   int n_fail = 0;
   int cmp_count = 0;
   register_page_context_stack u_dut (.clock(clock), .rst(rst), .clock_en(clock_en),
      .reg_access(reg_access), .reg_rdata(reg_rdata), .irq_event(irq_event),
      .page_select_out(page_select_out), .auto_page_enable_out(auto_page_enable_out));
   core_irq_model u_core (.clock(clock), .irq_event(irq_event));
   // Compare and register access helpers
   task check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task wr(input logic [1:0] s, input logic [7:0] d);
      @(posedge clock) reg_access <= '{1'b1, s, d};
      @(posedge clock) reg_access <= '{1'b0, s, ~d};
   endtask : wr
   task look(input logic [1:0] s, input logic [7:0] e);
      @(posedge clock) reg_access <= '{1'b0, s, 8'h00};
      @(posedge clock) #1 check(reg_rdata, e);
   endtask : look
   // Scenarios
   task t_disable;
      look(2'h3, 8'h01);
      wr(2'h3, 8'hff);
      look(2'h3, 8'h01);
      wr(2'h3, 8'h00);
      u_core.enter(8'h02);
      u_core.leave();
      look(2'h0, 8'h00);
      check({7'h00, auto_page_enable_out}, 8'h00);
      wr(2'h3, 8'h01);
   endtask : t_disable
   task t_nested;
      wr(2'h0, 8'h0f);
      u_core.enter(8'h02);
      u_core.enter(8'h00);
      look(2'h0, 8'h00);
      look(2'h1, 8'h02);
      look(2'h2, 8'h0f);
      u_core.leave();
      look(2'h0, 8'h02);
      check(page_select_out, 8'h02);
      look(2'h1, 8'h0f);
      look(2'h2, 8'h00);
      u_core.leave();
      look(2'h0, 8'h0f);
   endtask : t_nested
   task t_alter;
      wr(2'h2, 8'h33);
      wr(2'h1, 8'h03);
      look(2'h0, 8'h0f);
      look(2'h2, 8'h33);
      u_core.leave();
      look(2'h0, 8'h03);
      wr(2'h2, 8'h55);
      u_core.enter(8'h01);
      look(2'h2, 8'h33);
   endtask : t_alter
   // Frozen clock enable: strobe and write must be ignored
   task t_freeze;
      @(posedge clock) clock_en <= 1'b0;
      u_core.enter(8'h02);
      wr(2'h0, 8'h44);
      @(posedge clock) clock_en <= 1'b1;
      look(2'h0, 8'h01);
      look(2'h1, 8'h03);
      check(page_select_out, 8'h01);
   endtask : t_freeze
   // Reset in mid-run, selector parked on page select
   task t_reset;
      @(posedge clock) reg_access <= '0;
      @(posedge clock) rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      look(2'h3, 8'h01);
      look(2'h2, 8'h00);
      check(page_select_out, 8'h00);
      check({7'h00, auto_page_enable_out}, 8'h01);
   endtask : t_reset
   task print_verdict;
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // Clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Hang guard
   initial begin
      #5000;
      n_fail++;
      print_verdict();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      clock_en = 1'b1;
      reg_access = '0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      t_disable();
      t_nested();
      t_alter();
      t_freeze();
      t_reset();
      print_verdict();
   end
endmodule : register_page_context_stack_test
`default_nettype wire
